// ### src/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned T_RESP_MS   = 250;
  localparam int unsigned T_HRST_MS   = 1500;
  localparam int unsigned T_QUIET_MS  = 3000;
  localparam int unsigned T_PWR_MS    = 1000;
  localparam int unsigned RESP_CYC_DEF  = T_RESP_MS * CYC_PER_MS;
  localparam int unsigned HRST_CYC_DEF  = T_HRST_MS * CYC_PER_MS;
  localparam int unsigned QUIET_CYC_DEF = T_QUIET_MS * CYC_PER_MS;
  localparam int unsigned PWR_CYC_DEF   = T_PWR_MS * CYC_PER_MS;

  // Command and reply type codes
  localparam logic [7:0] CMD_INFO  = 8'h01;
  localparam logic [7:0] CMD_UWR   = 8'h02;
  localparam logic [7:0] CMD_URD   = 8'h03;
  localparam logic [7:0] CMD_STORE = 8'h04;
  localparam logic [7:0] CMD_RESET = 8'h05;
  localparam logic [7:0] RSP_BIT   = 8'h40;
  localparam logic [7:0] ERR_BITS  = 8'hC0;
  localparam logic [7:0] LOW6_MASK = 8'h3F;
  localparam int         RSP_POS   = 6;

  // Payload sizes and selectors
  localparam logic [7:0] SEL_VER    = 8'h00;
  localparam logic [7:0] SEL_SER    = 8'h01;
  localparam logic [7:0] USER_BYTES = 8'h10;
  localparam logic [7:0] VER_LEN    = 8'h10;
  localparam logic [7:0] SER_LEN    = 8'h14;
  localparam logic [7:0] RST_ARGS   = 8'h03;
  localparam logic [7:0] INFO_MAX   = 8'h01;
  localparam int         VER_BYTES  = 16;
  localparam int         SER_BYTES  = 20;
  localparam logic [7:0] HDR_BYTES  = 8'h02;
  localparam logic [7:0] PKT_OVH    = 8'h04;

  // Reset function argument triples
  localparam logic [23:0] TRI_RELOAD  = 24'h081263;
  localparam logic [23:0] TRI_HRST    = 24'h0C1C61;
  localparam logic [23:0] TRI_PWR     = 24'h030B5F;
  localparam logic [23:0] TRI_REBOOT  = 24'h081930;
  localparam logic [23:0] TRI_FACTORY = 24'h0A0862;

  // Configuration word; top nibble is report/failsafe/watchdog, never saved
  localparam int          CFG_W         = 32;
  localparam logic [31:0] CFG_SAVE_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] CFG_FACTORY   = 32'h0000_0001;

  // Packet check word
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  // Reflected 16-bit check word, one byte at a time
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Byte k of an outgoing packet: type, length, payload, check low, check high
  function automatic logic [7:0] tx_pick(input logic [7:0] k, input logic [7:0] len,
                                         input logic [7:0] typ, input logic [7:0] pb,
                                         input logic [15:0] crc);
    logic [7:0] r;
    r = 8'h00;
    if (k == 8'h00) r = typ;
    else if (k == 8'h01) r = len;
    else if (k < len + HDR_BYTES) r = pb;
    else if (k == len + HDR_BYTES) r = ~crc[7:0];
    else r = ~crc[15:8];
    return r;
  endfunction

endpackage

// ### src/lcd_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Byte stream both ways, valid/ready, one clock
interface lcd_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;

  modport dev (input h2d_data, input h2d_valid, output h2d_ready,
               output d2h_data, output d2h_valid, input d2h_ready);
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
                input d2h_data, input d2h_valid, output d2h_ready);
endinterface
`default_nettype wire

// ### src/lcd_cmd_dev.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1 - Info query 0x01, selector 0/empty version, 1 serial
// R2 - Version reply 0x41 with 16-byte text
// R3 - Serial reply 0x41 with 20-byte text
// R4 - Write 0x02 exactly 16 bytes, ack 0x42
// R5 - Read 0x03 empty, reply 0x43 with bytes
// R6 - Power-up loads configuration from boot state
// R7 - Store 0x04 saves current configuration, reply 0x44
// R8 - Reports, failsafe, watchdog never saved
// R9 - Reset 0x05, three bytes; 8,18,99 reloads boot
// R10 - Reload: ack, apply, keep accepting commands
// R11 - 12,28,97: ack, then pulse host reset
// R12 - After 1.5 s host reset, soft reboot
// R13 - 3,11,95: ack, then power pulse
// R14 - 8,25,48: acknowledged soft reboot
// R15 - After reboot ack, ignore packets 3 s
// R16 - 10,8,98: factory boot state, then reboot
// R17 - Factory reset keeps user area
// R18 - Reset functions acknowledged 0x45 before acting
// R19 - Host keeps ATX pins at default use
// R20 - Reply low six bits equal command's
// R21 - Packets end with LSB-first 16-bit check
// R22 - Every packet answered within 250 ms; packets with a bad check word are dropped with no reply
// R23 - Bad triple or length answered error, no action
module lcd_cmd_dev
  import lcd_cmd_pkg::*;
#(
  parameter int unsigned            HRST_CYC  = HRST_CYC_DEF,
  parameter int unsigned            PWR_CYC   = PWR_CYC_DEF,
  parameter int unsigned            QUIET_CYC = QUIET_CYC_DEF,
  // Arbitrary identity texts
  parameter logic [8*VER_BYTES-1:0] VER_STR   = "MODULE:h1v0,f1v0",
  parameter logic [8*SER_BYTES-1:0] SER_STR   = "SN000000000000000001"
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Packet link to host
  lcd_link_if.dev               lnk,
  // Module configuration
  input  wire logic [CFG_W-1:0] cfg_live,
  output logic      [CFG_W-1:0] cfg_out,
  output logic                  cfg_load,
  output logic                  soft_reboot,
  // ATX control pins
  output logic                  host_rst_out,
  output logic                  host_pwr_out
);

  typedef enum logic [3:0] {
    S_BOOT, S_TYPE, S_LEN, S_DATA, S_CRC0, S_CRC1,
    S_EXEC, S_TX, S_ACT, S_HRST, S_PWR, S_QUIET
  } st_e;
  typedef enum logic [1:0] {SRC_NONE, SRC_VER, SRC_SER, SRC_USER} src_e;
  typedef enum logic [2:0] {
    ACT_NONE, ACT_RELOAD, ACT_HRST, ACT_PWR, ACT_REBOOT, ACT_FACTORY
  } act_e;

  typedef struct packed {
    st_e              st;
    logic [7:0]       typ;
    logic [7:0]       len;
    logic [7:0]       cnt;
    logic [15:0][7:0] rx;
    logic [15:0]      crc;
    logic [7:0]       crc_lo;
    logic [7:0]       rtyp;
    logic [7:0]       rlen;
    src_e             src;
    act_e             act;
    logic [7:0]       tidx;
    logic [7:0]       txb;
    logic             txv;
    logic             rxr;
    logic [15:0][7:0] user;
    logic [CFG_W-1:0] boot;
    logic [CFG_W-1:0] cfg;
    logic             cfg_ld;
    logic             hrst;
    logic             hpwr;
    logic             reboot;
    logic [31:0]      tmr;
  } dev_s;

  dev_s q;
  dev_s d;

  // Payload byte i of the current reply
  function automatic logic [7:0] pay(input src_e s, input logic [7:0] i,
                                     input logic [15:0][7:0] u);
    logic [7:0] b;
    b = 8'h00;
    case (s)
      SRC_VER:  if (i < VER_LEN) b = VER_STR[8*(VER_BYTES-1-int'(i[3:0]))+:8]; // R2
      SRC_SER:  if (i < SER_LEN) b = SER_STR[8*(SER_BYTES-1-int'(i[4:0]))+:8]; // R3
      SRC_USER: if (i < USER_BYTES) b = u[i[3:0]]; // R5
      default:  b = 8'h00;
    endcase
    return b;
  endfunction

  // Next-state logic for parser, executor and actions
  always_comb begin
    logic [7:0]  b;
    logic [7:0]  k1;
    logic [23:0] tri3;
    logic        ok;
    logic        go_reboot;
    b         = lnk.h2d_data;
    k1        = q.tidx + 8'h01;
    tri3      = {q.rx[0], q.rx[1], q.rx[2]};
    ok        = 1'b0;
    go_reboot = 1'b0;
    d         = q;
    d.cfg_ld  = 1'b0;
    d.reboot  = 1'b0;
    unique case (q.st)
      S_BOOT: begin
        d.boot   = CFG_FACTORY; // R6
        d.cfg    = CFG_FACTORY;
        d.cfg_ld = 1'b1; // R6
        d.st     = S_TYPE;
      end
      S_TYPE: if (lnk.h2d_valid) begin
        d.typ = b;
        d.crc = crc_upd(CRC_INIT, b); // R21
        d.st  = S_LEN;
      end
      S_LEN: if (lnk.h2d_valid) begin
        d.len = b;
        d.cnt = 8'h00;
        d.crc = crc_upd(q.crc, b);
        d.st  = (b == 8'h00) ? S_CRC0 : S_DATA;
      end
      // Long payloads are consumed to keep framing; only 16 bytes kept
      S_DATA: if (lnk.h2d_valid) begin
        if (q.cnt < USER_BYTES) d.rx[q.cnt[3:0]] = b;
        d.crc = crc_upd(q.crc, b);
        d.cnt = q.cnt + 8'h01;
        if (q.cnt + 8'h01 == q.len) d.st = S_CRC0;
      end
      S_CRC0: if (lnk.h2d_valid) begin
        d.crc_lo = b;
        d.st     = S_CRC1;
      end
      // Bad check word drops the packet silently; host retries
      S_CRC1: if (lnk.h2d_valid) begin
        d.st = ({b, q.crc_lo} == ~q.crc) ? S_EXEC : S_TYPE; // R21
      end
      S_EXEC: begin
        d.rlen = 8'h00;
        d.src  = SRC_NONE;
        d.act  = ACT_NONE;
        case (q.typ)
          CMD_INFO: begin
            if (q.len == 8'h00 || (q.len == INFO_MAX && q.rx[0] == SEL_VER)) begin // R1
              ok     = 1'b1;
              d.rlen = VER_LEN; // R2
              d.src  = SRC_VER;
            end else if (q.len == INFO_MAX && q.rx[0] == SEL_SER) begin // R1
              ok     = 1'b1;
              d.rlen = SER_LEN; // R3
              d.src  = SRC_SER;
            end
          end
          CMD_UWR: if (q.len == USER_BYTES) begin // R4
            ok     = 1'b1;
            d.user = q.rx; // R4
          end
          CMD_URD: if (q.len == 8'h00) begin
            ok     = 1'b1;
            d.rlen = USER_BYTES; // R5
            d.src  = SRC_USER;
          end
          CMD_STORE: if (q.len == 8'h00) begin
            ok     = 1'b1;
            d.boot = cfg_live & CFG_SAVE_MASK; // R7 R8
          end
          CMD_RESET: if (q.len == RST_ARGS) begin // R9
            ok = 1'b1;
            case (tri3)
              TRI_RELOAD:  d.act = ACT_RELOAD; // R9
              TRI_HRST:    d.act = ACT_HRST; // R11
              TRI_PWR:     d.act = ACT_PWR; // R13
              TRI_REBOOT:  d.act = ACT_REBOOT; // R14
              TRI_FACTORY: d.act = ACT_FACTORY; // R16
              default:     ok = 1'b0; // R23
            endcase
          end
          default: ok = 1'b0;
        endcase
        // Error replies keep the empty defaults and trigger nothing
        d.rtyp = (ok ? RSP_BIT : ERR_BITS) | (q.typ & LOW6_MASK); // R20 R23
        d.tidx = 8'h00;
        d.crc  = CRC_INIT;
        d.txb  = d.rtyp;
        d.txv  = 1'b1; // R22
        d.st   = S_TX;
      end
      // Reply goes out whole before any action starts
      S_TX: if (lnk.d2h_ready) begin
        if (q.tidx < q.rlen + HDR_BYTES) d.crc = crc_upd(q.crc, q.txb); // R21
        d.tidx = k1;
        if (k1 == q.rlen + PKT_OVH) begin
          d.txv = 1'b0;
          d.st  = S_ACT; // R18
        end else begin
          d.txb = tx_pick(k1, q.rlen, q.rtyp, pay(q.src, k1 - HDR_BYTES, q.user), d.crc);
        end
      end
      S_ACT: begin
        d.tmr = '0;
        d.st  = S_TYPE;
        case (q.act)
          ACT_RELOAD: begin
            d.cfg    = q.boot; // R10
            d.cfg_ld = 1'b1;
          end
          ACT_HRST: begin
            d.hrst = 1'b1; // R11
            d.st   = S_HRST;
          end
          ACT_PWR: begin
            d.hpwr = 1'b1; // R13
            d.st   = S_PWR;
          end
          ACT_REBOOT: go_reboot = 1'b1; // R14
          ACT_FACTORY: begin
            d.boot    = CFG_FACTORY; // R16 R17
            go_reboot = 1'b1;
          end
          default: d.st = S_TYPE;
        endcase
      end
      S_HRST: begin
        d.tmr = q.tmr + 32'h0000_0001;
        if (q.tmr == 32'(HRST_CYC - 1)) begin
          d.hrst    = 1'b0;
          go_reboot = 1'b1; // R12
        end
      end
      S_PWR: begin
        d.tmr = q.tmr + 32'h0000_0001;
        if (q.tmr == 32'(PWR_CYC - 1)) begin
          d.hpwr = 1'b0; // R13
          d.st   = S_TYPE;
        end
      end
      // Bytes arriving now are taken and dropped
      S_QUIET: begin
        d.tmr = q.tmr + 32'h0000_0001;
        if (q.tmr == 32'(QUIET_CYC - 1)) d.st = S_TYPE; // R15
      end
    endcase
    // Soft reboot reloads the boot state and goes quiet
    if (go_reboot) begin
      d.reboot = 1'b1; // R14
      d.cfg    = d.boot;
      d.cfg_ld = 1'b1;
      d.tmr    = '0;
      d.st     = S_QUIET; // R15
    end
    d.rxr = (d.st inside {S_TYPE, S_LEN, S_DATA, S_CRC0, S_CRC1, S_QUIET}); // R10
  end

  // Whole state in one register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign lnk.h2d_ready = q.rxr;
  assign lnk.d2h_data  = q.txb;
  assign lnk.d2h_valid = q.txv;
  assign cfg_out       = q.cfg;
  assign cfg_load      = q.cfg_ld;
  assign soft_reboot   = q.reboot;
  assign host_rst_out  = q.hrst;
  assign host_pwr_out  = q.hpwr;

endmodule
`default_nettype wire

// ### src/lcd_cmd_host.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_cmd_host
  import lcd_cmd_pkg::*;
#(
  parameter int unsigned RESP_CYC  = RESP_CYC_DEF,
  parameter int unsigned QUIET_CYC = QUIET_CYC_DEF,
  parameter int unsigned RETRIES   = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Packet link to device
  lcd_link_if.host              lnk,
  // Command request
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire logic [7:0]       cmd_type,
  input  wire logic [7:0]       cmd_len,
  input  wire logic [15:0][7:0] cmd_data,
  // Command answer
  output logic                  rsp_valid,
  output logic                  rsp_timeout,
  output logic      [7:0]       rsp_type,
  output logic      [7:0]       rsp_len,
  output logic      [19:0][7:0] rsp_data
);

  typedef enum logic [1:0] {H_IDLE, H_TX, H_WAIT, H_HOLD} st_e;
  typedef enum logic [2:0] {P_TYPE, P_LEN, P_DATA, P_C0, P_C1} rx_e;

  typedef struct packed {
    st_e              st;
    rx_e              p;
    logic [7:0]       ctyp;
    logic [7:0]       clen;
    logic [15:0][7:0] cdat;
    logic [7:0]       tidx;
    logic [15:0]      crc;
    logic [7:0]       txb;
    logic             txv;
    logic [31:0]      tmr;
    logic [3:0]       retry;
    logic [7:0]       rtyp;
    logic [7:0]       rlen;
    logic [7:0]       rcnt;
    logic [19:0][7:0] rdat;
    logic [7:0]       crc_lo;
    logic [15:0]      rcrc;
    logic             rxr;
    logic             cmd_rdy;
    logic             rsp_v;
    logic             rsp_to;
    logic [7:0]       otyp;
    logic [7:0]       olen;
    logic [19:0][7:0] odat;
  } host_s;

  host_s q;
  host_s d;

  // Transmit, wait with timeout and retry, hold off after reboot acks
  always_comb begin
    logic [7:0]  b;
    logic [7:0]  k1;
    logic        acc;
    logic        send;
    logic        hold;
    b       = lnk.d2h_data;
    k1      = q.tidx + 8'h01;
    acc     = 1'b0;
    send    = 1'b0;
    hold    = 1'b0;
    d       = q;
    d.rsp_v = 1'b0;
    unique case (q.st)
      H_IDLE: begin
        if (q.cmd_rdy && cmd_valid) begin
          d.ctyp    = cmd_type;
          d.clen    = cmd_len;
          d.cdat    = cmd_data;
          d.retry   = 4'h0;
          d.cmd_rdy = 1'b0;
          send      = 1'b1;
        end else begin
          d.cmd_rdy = 1'b1;
        end
      end
      H_TX: if (lnk.h2d_ready) begin
        if (q.tidx < q.clen + HDR_BYTES) d.crc = crc_upd(q.crc, q.txb); // R21
        d.tidx = k1;
        if (k1 == q.clen + PKT_OVH) begin
          d.txv = 1'b0;
          d.tmr = 32'h0000_0000;
          d.p   = P_TYPE;
          d.st  = H_WAIT;
        end else begin
          d.txb = tx_pick(k1, q.clen, q.ctyp, q.cdat[4'(k1 - HDR_BYTES)], d.crc);
        end
      end
      H_WAIT: begin
        if (lnk.d2h_valid) begin
          unique case (q.p)
            P_TYPE: begin
              d.rtyp = b;
              d.rcrc = crc_upd(CRC_INIT, b);
              d.p    = P_LEN;
            end
            P_LEN: begin
              d.rlen = b;
              d.rcnt = 8'h00;
              d.rcrc = crc_upd(q.rcrc, b);
              d.p    = (b == 8'h00) ? P_C0 : P_DATA;
            end
            P_DATA: begin
              if (q.rcnt < SER_LEN) d.rdat[q.rcnt[4:0]] = b;
              d.rcrc = crc_upd(q.rcrc, b);
              d.rcnt = q.rcnt + 8'h01;
              if (q.rcnt + 8'h01 == q.rlen) d.p = P_C0;
            end
            P_C0: begin
              d.crc_lo = b;
              d.p      = P_C1;
            end
            P_C1: begin
              d.p = P_TYPE;
              // Reports and foreign replies lack bit 6 or mismatch
              acc = ({b, q.crc_lo} == ~q.rcrc) && q.rtyp[RSP_POS]
                    && ((q.rtyp & LOW6_MASK) == (q.ctyp & LOW6_MASK));
            end
          endcase
        end
        if (acc) begin
          d.rsp_v  = 1'b1;
          d.rsp_to = 1'b0;
          d.otyp   = q.rtyp;
          d.olen   = q.rlen;
          d.odat   = d.rdat;
          hold = (q.rtyp == (RSP_BIT | CMD_RESET)) && (q.ctyp == CMD_RESET)
                 && ({q.cdat[0], q.cdat[1], q.cdat[2]} inside
                     {TRI_REBOOT, TRI_FACTORY, TRI_HRST});
          d.tmr     = 32'h0000_0000;
          d.st      = hold ? H_HOLD : H_IDLE;
          d.cmd_rdy = !hold;
        end else if (q.tmr == 32'(RESP_CYC - 1)) begin
          // Unanswered: resend until the retry budget runs out
          d.p   = P_TYPE;
          d.tmr = 32'h0000_0000;
          if (q.retry == 4'(RETRIES - 1)) begin
            d.rsp_v   = 1'b1;
            d.rsp_to  = 1'b1;
            d.cmd_rdy = 1'b1;
            d.st      = H_IDLE;
          end else begin
            d.retry = q.retry + 4'h1; // R22
            send    = 1'b1;
          end
        end else begin
          d.tmr = q.tmr + 32'h0000_0001;
        end
      end
      // Device is rebooting and deaf; stay silent
      H_HOLD: begin
        d.tmr = q.tmr + 32'h0000_0001;
        if (q.tmr == 32'(QUIET_CYC - 1)) begin
          d.st      = H_IDLE;
          d.cmd_rdy = 1'b1;
        end
      end
    endcase
    if (send) begin
      d.tidx = 8'h00;
      d.crc  = CRC_INIT;
      d.txb  = d.ctyp;
      d.txv  = 1'b1;
      d.st   = H_TX;
    end
    d.rxr = (d.st == H_WAIT);
  end

  // Whole state in one register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign lnk.h2d_data  = q.txb;
  assign lnk.h2d_valid = q.txv;
  assign lnk.d2h_ready = q.rxr;
  assign cmd_ready     = q.cmd_rdy;
  assign rsp_valid     = q.rsp_v;
  assign rsp_timeout   = q.rsp_to;
  assign rsp_type      = q.otyp;
  assign rsp_len       = q.olen;
  assign rsp_data      = q.odat;

endmodule
`default_nettype wire

// ### bench/lcd_link_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lcd_link_monitor
  import lcd_cmd_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Host to device
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  // Device to host
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  logic [7:0] h_idx_q, h_len_q, h_typ_q, d_idx_q, d_len_q, d_typ_q;
  logic       h_take, d_take, h_last, d_last;

  // Packet ends on its second check byte
  assign h_take = h2d_valid && h2d_ready;
  assign d_take = d2h_valid && d2h_ready;
  assign h_last = (h_idx_q > 8'h01) && (h_idx_q == h_len_q + 8'h03);
  assign d_last = (d_idx_q > 8'h01) && (d_idx_q == d_len_q + 8'h03);

  // Byte position trackers for both directions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      h_idx_q <= 8'h00;
      h_len_q <= 8'h00;
      h_typ_q <= 8'h00;
      d_idx_q <= 8'h00;
      d_len_q <= 8'h00;
      d_typ_q <= 8'h00;
    end else begin
      if (h_take) begin
        if (h_idx_q == 8'h00) h_typ_q <= h2d_data;
        if (h_idx_q == 8'h01) h_len_q <= h2d_data;
        h_idx_q <= h_last ? 8'h00 : h_idx_q + 8'h01;
      end
      if (d_take) begin
        if (d_idx_q == 8'h00) d_typ_q <= d2h_data;
        if (d_idx_q == 8'h01) d_len_q <= d2h_data;
        d_idx_q <= d_last ? 8'h00 : d_idx_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_h_end;
    h_take && h_last;
  endsequence
  sequence s_d_first;
    d2h_valid && (d_idx_q == 8'h00);
  endsequence
  sequence s_d_len;
    d2h_valid && (d_idx_q == 8'h01);
  endsequence

  property p_h_hold;
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
  endproperty
  property p_d_hold;
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
  endproperty
  property p_answer;
    s_h_end |-> ##2 s_d_first;
  endproperty
  property p_type_bit;
    s_d_first |-> d2h_data[RSP_POS];
  endproperty
  property p_type_low;
    s_d_first |-> (d2h_data & LOW6_MASK) == (h_typ_q & LOW6_MASK);
  endproperty
  property p_len_ack;
    s_d_len ##0 (d_typ_q == 8'h42 || d_typ_q == 8'h44 || d_typ_q == 8'h45) |-> d2h_data == 8'h00;
  endproperty
  property p_len_urd;
    s_d_len ##0 (d_typ_q == 8'h43) |-> d2h_data == USER_BYTES;
  endproperty
  property p_len_info;
    s_d_len ##0 (d_typ_q == 8'h41) |-> d2h_data == VER_LEN || d2h_data == SER_LEN;
  endproperty
  property p_len_err;
    s_d_len ##0 (d_typ_q[7:6] == 2'b11) |-> d2h_data == 8'h00;
  endproperty
  property p_busy;
    d2h_valid |-> !h2d_ready;
  endproperty

  a_h_hold: assert property (p_h_hold) else $error("host byte moved");
  a_d_hold: assert property (p_d_hold) else $error("reply byte moved");
  a_answer: assert property (p_answer) else $error("reply late");
  a_type_bit: assert property (p_type_bit) else $error("type bit 6 clear");
  a_type_low: assert property (p_type_low) else $error("type low bits");
  a_len_ack: assert property (p_len_ack) else $error("ack not empty");
  a_len_urd: assert property (p_len_urd) else $error("read length");
  a_len_info: assert property (p_len_info) else $error("info length");
  a_len_err: assert property (p_len_err) else $error("error not empty");
  a_busy: assert property (p_busy) else $error("ready while replying");
endmodule
`default_nettype wire

// ### bench/test_module_info_flash_boot_reset_cmds.sv
`timescale 1ns/1ns
`default_nettype none
module test_module_info_flash_boot_reset_cmds
  import lcd_cmd_pkg::*;
;
  // Short pin and quiet spans; host quiet outlasts the device's
  localparam int unsigned HRST = 50;
  localparam int unsigned PWR  = 40;
  localparam int unsigned DQ   = 60;
  localparam int unsigned HQ   = 150;
  logic             clk, reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_timeout;
  logic             cfg_load, soft_reboot, host_rst_out, host_pwr_out;
  logic [7:0]       cmd_type, cmd_len, rsp_type, rsp_len;
  logic [15:0][7:0] cmd_data, user, z;
  logic [19:0][7:0] rsp_data;
  logic [CFG_W-1:0] cfg_live, cfg_out, last_cfg;
  int               n_fail = 0, n_compared = 0, n_load = 0, n_boot = 0;
  int               rst_len = 0, pwr_len = 0;

  lcd_link_if u_lcd_link_if ();
  lcd_cmd_dev #(.HRST_CYC(HRST), .PWR_CYC(PWR), .QUIET_CYC(DQ)) u_lcd_cmd_dev (
    .clk, .reset_n, .lnk(u_lcd_link_if.dev), .cfg_live, .cfg_out, .cfg_load,
    .soft_reboot, .host_rst_out, .host_pwr_out);
  lcd_cmd_host #(.RESP_CYC(500), .QUIET_CYC(HQ)) u_lcd_cmd_host (
    .clk, .reset_n, .lnk(u_lcd_link_if.host), .cmd_valid, .cmd_ready, .cmd_type,
    .cmd_len, .cmd_data, .rsp_valid, .rsp_timeout, .rsp_type, .rsp_len, .rsp_data);
  lcd_link_monitor u_lcd_link_monitor (
    .clk, .reset_n, .h2d_data(u_lcd_link_if.h2d_data),
    .h2d_valid(u_lcd_link_if.h2d_valid), .h2d_ready(u_lcd_link_if.h2d_ready),
    .d2h_data(u_lcd_link_if.d2h_data), .d2h_valid(u_lcd_link_if.d2h_valid),
    .d2h_ready(u_lcd_link_if.d2h_ready));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pin high cycles and load events; one pulse of each pin per run
  always @(posedge clk) begin
    if (host_rst_out === 1'b1) rst_len <= rst_len + 1;
    if (host_pwr_out === 1'b1) pwr_len <= pwr_len + 1;
    if (soft_reboot === 1'b1) n_boot <= n_boot + 1;
    if (cfg_load === 1'b1) begin
      n_load <= n_load + 1;
      last_cfg <= cfg_out;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One command through the host end; bounded waits on both handshakes
  task automatic send(input logic [7:0] t, input logic [7:0] l, input logic [15:0][7:0] d);
    for (int k = 0; cmd_ready !== 1'b1 && k < 2000; k++) tick(1);
    cmd_type = t;
    cmd_len = l;
    cmd_data = d;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    for (int k = 0; rsp_valid !== 1'b1 && k < 5000; k++) tick(1);
    check("answered", 32'h1, {31'h0, rsp_valid === 1'b1 && rsp_timeout === 1'b0});
  endtask

  function automatic logic [15:0][7:0] trip(input logic [23:0] t);
    return {104'h0, t[7:0], t[15:8], t[23:16]};
  endfunction

  task automatic t_read;
    send(CMD_URD, 8'h00, z);
    check("read type", 32'h43, rsp_type);
    for (int i = 0; i < 16; i++) check("user byte", user[i], rsp_data[i]);
  endtask

  task automatic t_info;
    send(CMD_INFO, 8'h00, z);
    check("ver type", 32'h41, rsp_type);
    check("ver len", VER_LEN, rsp_len);
    check("ver first", "M", rsp_data[0]);
    check("ver last", "0", rsp_data[15]);
    send(CMD_INFO, 8'h01, trip({SEL_VER, 16'h0000}));
    check("sel0 len", VER_LEN, rsp_len);
    send(CMD_INFO, 8'h01, trip({SEL_SER, 16'h0000}));
    check("ser len", SER_LEN, rsp_len);
    check("ser first", "S", rsp_data[0]);
    check("ser last", "1", rsp_data[19]);
    send(CMD_INFO, 8'h01, trip(24'h020000));
    check("bad sel", ERR_BITS | CMD_INFO, rsp_type);
  endtask

  task automatic t_user;
    for (int i = 0; i < 16; i++) user[i] = 8'hA0 + 8'(i);
    send(CMD_UWR, USER_BYTES, user);
    check("write ack", 32'h42, rsp_type);
    send(CMD_UWR, 8'h0F, ~user);
    check("short write", ERR_BITS | CMD_UWR, rsp_type);
    t_read();
  endtask

  // Store masks unsaved bits; reload applies boot and stays responsive
  task automatic t_store;
    int k;
    cfg_live = 32'hF234_5678;
    send(CMD_STORE, 8'h00, z);
    check("store ack", 32'h44, rsp_type);
    cfg_live = 32'h0000_00FF;
    k = n_load;
    send(CMD_RESET, RST_ARGS, trip(TRI_RELOAD));
    check("reload ack", 32'h45, rsp_type);
    tick(3);
    check("reload count", k + 1, n_load);
    check("reload cfg", 32'h0234_5678, last_cfg);
    t_read();
  endtask

  task automatic t_pins;
    int k;
    k = n_boot;
    send(CMD_RESET, RST_ARGS, trip(TRI_HRST));
    check("hrst ack", 32'h45, rsp_type);
    send(CMD_INFO, 8'h00, z);
    check("hrst width", HRST, rst_len);
    check("hrst reboot", k + 1, n_boot);
    send(CMD_RESET, RST_ARGS, trip(TRI_PWR));
    check("pwr ack", 32'h45, rsp_type);
    send(CMD_INFO, 8'h00, z);
    check("pwr width", PWR, pwr_len);
  endtask

  // Reboot keeps boot; factory restores it; bad triple does nothing
  task automatic t_reboot;
    int k;
    int j;
    k = n_boot;
    send(CMD_RESET, RST_ARGS, trip(TRI_REBOOT));
    check("boot ack", 32'h45, rsp_type);
    send(CMD_INFO, 8'h00, z);
    check("boot count", k + 1, n_boot);
    check("boot cfg", 32'h0234_5678, last_cfg);
    send(CMD_RESET, RST_ARGS, trip(TRI_FACTORY));
    check("fact ack", 32'h45, rsp_type);
    send(CMD_RESET, RST_ARGS, trip(TRI_RELOAD));
    tick(3);
    check("fact cfg", CFG_FACTORY, last_cfg);
    t_read();
    k = n_boot;
    j = n_load;
    send(CMD_RESET, RST_ARGS, trip(24'h081262));
    check("bad triple", ERR_BITS | CMD_RESET, rsp_type);
    tick(5);
    check("bad no boot", k, n_boot);
    check("bad no load", j, n_load);
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    z = '0;
    user = '0;
    cfg_live = 32'h0000_0000;
    tick(4);
    reset_n = 1'b1;
    tick(4);
    check("power-up cfg", CFG_FACTORY, last_cfg);
    t_info();
    t_user();
    t_store();
    t_pins();
    t_reboot();
    test_done();
  end

  // Watchdog, far beyond the thousand or so cycles expected
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
